// >>> rtl/scp_map.svh
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
// Printed register indices; the byte address is four times the index.
`define SCP_IDX_DIVIDE_CONTROL 12'h061
`define SCP_IDX_OSC_TRIM 12'h066
// Status register at a byte address of its own.
`define SCP_ADDR_STATUS 12'h000
// Field positions of the divide control register.
`define SCP_BIT_CHANGE_EN 7
`define SCP_SEL_MSB 3
// Reset select codes, chosen by the divide-by-eight fuse.
`define SCP_SEL_DIV1 4'h0
`define SCP_SEL_DIV8 4'h3
// Highest defined select code (divide by 256).
`define SCP_SEL_MAX 4'h8
// Unlock value and window length in system clock cycles.
`define SCP_UNLOCK_VALUE 8'h80
`define SCP_WINDOW_CYCLES 3'h4
// Default factory trim and nominal oscillator frequency in kHz.
`define SCP_TRIM_DEFAULT 8'h80
`define SCP_RC_NOMINAL_KHZ 32'h0000_1f40
// Field positions of the status register.
`define SCP_STAT_PENDING 0
`define SCP_STAT_ACT_MSB 11
`define SCP_STAT_ACT_LSB 8
`define SCP_STAT_KHZ_MSB 31
`define SCP_STAT_KHZ_LSB 16
// Range select bit of the trim register.
`define SCP_BIT_TRIM_RANGE 7
// AXI responses.
`define SCP_RESP_OKAY 2'b00
`define SCP_RESP_SLVERR 2'b10
`endif

// >>> rtl/scp_pkg.sv
package scp_pkg;
   typedef enum logic [1:0] {
      SCP_LOCKED = 2'b01,
      SCP_OPEN = 2'b10
   } scp_unlock_type;
   typedef logic [3:0] scp_sel_type;
endpackage

// >>> rtl/scp_prescaler.sv
// Notes on behaviour
// - Fuse drives system clock onto output pin.
// - Clock output keeps running during chip reset.
// - Output pin carries the divided clock; the code holds it high at divide by one.
// - Division applies to I/O, CPU, flash.
// - No glitches or runt pulses when switching.
// - No intermediate period shorter than either.
// - New rate after T1+T2 to T1+2*T2.
// - Enable sets only when other bits zero.
// - Enable clears after four cycles or select write.
// - Rewriting enable neither extends nor clears window.
// - Reset select is fuse dependent: 0000 or 0011.
// - Any select value accepted after valid unlock.
// - Codes 0 to 8 divide by 1 to 256.
// - Chip reset loads factory trim value.
// - Trim writes retune the RC oscillator.
// - Trim bit 7 selects the frequency range.
// - Lower trim bits tune monotonically within range.
// - Trim calibrates the nominal 8 MHz oscillator.
`include "scp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module scp_prescaler
   import scp_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic core_rst_n,
   input wire logic clock_output_fuse,
   input wire logic reset_divide_by_eight_fuse,
   input wire logic [7:0] factory_trim,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic io_clock_domain,
   output logic cpu_clock_domain,
   output logic flash_clock_en,
   output logic clock_out_pin,
   output logic clock_out_pin_oe,
   output logic trim_range_select,
   output logic [6:0] trim_tune
);

   localparam logic [31:0] RC_NOMINAL_KHZ = `SCP_RC_NOMINAL_KHZ;

   // Terminal count of the ripple counter for a select code.
   function automatic logic [7:0] div_mask(input scp_sel_type sel);
      scp_sel_type s;
      s = (sel > `SCP_SEL_MAX) ? `SCP_SEL_MAX : sel;
      div_mask = 8'((9'h001 << s) - 9'h001);
   endfunction

   function automatic logic [11:0] byte_addr(input logic [11:0] idx);
      byte_addr = 12'(idx << 2);
   endfunction

   // True when a byte address selects the register with a printed index.
   function automatic logic reg_hit(input logic [11:0] addr,
                                    input logic [11:0] idx);
      reg_hit = (addr == byte_addr(idx));
   endfunction

   // Control register as software reads it; bits 6:4 stay zero.
   function automatic logic [31:0] ctrl_view(input logic is_open,
                                             input scp_sel_type sel);
      ctrl_view = 32'h0000_0000;
      ctrl_view[`SCP_BIT_CHANGE_EN] = is_open;
      ctrl_view[`SCP_SEL_MSB:0] = sel;
   endfunction

   // Status word: switch pending, active code and nominal RC frequency.
   function automatic logic [31:0] status_view(input logic pend,
                                               input scp_sel_type sel);
      status_view = 32'h0000_0000;
      status_view[`SCP_STAT_PENDING] = pend;
      status_view[`SCP_STAT_ACT_MSB:`SCP_STAT_ACT_LSB] = sel;
      status_view[`SCP_STAT_KHZ_MSB:`SCP_STAT_KHZ_LSB] =
         RC_NOMINAL_KHZ[15:0];
   endfunction

   scp_sel_type active_sel_q;
   scp_sel_type divide_select_q;
   scp_sel_type pending_sel_q;
   logic pending_q;
   logic [7:0] cnt_q;
   logic tick_q;
   logic level_q;
   scp_unlock_type unlock_q;
   logic [2:0] window_q;
   logic [7:0] trim_q;
   logic [7:0] mask;
   logic boundary;
   scp_sel_type reset_sel;

   // Write channel holding registers.
   logic aw_held_q;
   logic w_held_q;
   logic [11:0] awaddr_q;
   logic [7:0] wbyte_q;
   logic wlane_q;
   logic do_write;
   logic wr_ctrl;
   logic wr_trim;
   logic wr_ok;
   logic wr_unlock;
   logic wr_select;
   logic [31:0] rd_word;
   logic [1:0] rd_resp;

   assign mask = div_mask(active_sel_q);
   assign boundary = (cnt_q == mask);
   assign reset_sel = reset_divide_by_eight_fuse ? `SCP_SEL_DIV8
                                                 : `SCP_SEL_DIV1;

   // Ripple counter on the undivided clock; a switch only happens at the
   // end of a whole old period and restarts the counter from zero.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 8'h00;
      end else if (boundary) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Active division follows the pending code at an old period boundary.
   // Switching only there keeps every period whole, so no intermediate
   // period is shorter than the old or the new one.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         active_sel_q <= `SCP_SEL_DIV1;
      end else if (boundary && pending_q) begin
         active_sel_q <= pending_sel_q;
      end
   end

   // A new request wins over a switch that completes in the same cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pending_q <= 1'b0;
         pending_sel_q <= `SCP_SEL_DIV1;
      end else if (!core_rst_n) begin
         pending_q <= (reset_sel != active_sel_q);
         pending_sel_q <= reset_sel;
      end else if (wr_select) begin
         pending_q <= 1'b1;
         pending_sel_q <= wbyte_q[`SCP_SEL_MSB:0];
      end else if (boundary) begin
         pending_q <= 1'b0;
      end
   end

   // One enable pulse per system clock period, shared by all domains.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= boundary;
      end
   end

   // Clock level: high for half of each period; divide by one holds it
   // high since a flop cannot toggle at the source rate.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level_q <= 1'b0;
      end else if (mask == 8'h00) begin
         level_q <= 1'b1;
      end else begin
         level_q <= ((cnt_q + 8'h01) & mask) <= (mask >> 1);
      end
   end

   assign io_clock_domain = tick_q;
   assign cpu_clock_domain = tick_q;
   assign flash_clock_en = tick_q;

   // Pin level follows the divided clock, also while the chip is held
   // in reset.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clock_out_pin <= 1'b0;
      end else begin
         clock_out_pin <= clock_output_fuse & level_q;
      end
   end

   // The fuse alone takes the pin over from its normal function.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clock_out_pin_oe <= 1'b0;
      end else begin
         clock_out_pin_oe <= clock_output_fuse;
      end
   end

   // Unlock window counted in system clock cycles.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         unlock_q <= SCP_LOCKED;
         window_q <= 3'h0;
      end else if (!core_rst_n) begin
         unlock_q <= SCP_LOCKED;
         window_q <= 3'h0;
      end else begin
         case (unlock_q)
            SCP_LOCKED: begin
               if (wr_unlock) begin
                  unlock_q <= SCP_OPEN;
                  window_q <= 3'h0;
               end
            end
            SCP_OPEN: begin
               if (wr_select) begin
                  unlock_q <= SCP_LOCKED;
               end else if (tick_q) begin
                  // A repeated unlock write changes nothing here.
                  if (window_q == `SCP_WINDOW_CYCLES - 3'h1) begin
                     unlock_q <= SCP_LOCKED;
                  end
                  window_q <= window_q + 3'h1;
               end
            end
            default: begin
               unlock_q <= SCP_LOCKED;
            end
         endcase
      end
   end

   // Readable copy of the last accepted select code.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         divide_select_q <= `SCP_SEL_DIV1;
      end else if (!core_rst_n) begin
         divide_select_q <= reset_sel;
      end else if (wr_select) begin
         divide_select_q <= wbyte_q[`SCP_SEL_MSB:0];
      end
   end

   // Trim register reloads the factory value during chip reset.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trim_q <= `SCP_TRIM_DEFAULT;
      end else if (!core_rst_n) begin
         trim_q <= factory_trim;
      end else if (wr_trim) begin
         trim_q <= wbyte_q;
      end
   end

   assign trim_range_select = trim_q[`SCP_BIT_TRIM_RANGE];
   assign trim_tune = trim_q[6:0];

   // Write path: address and data are taken in either order.
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   // Write decode; during chip reset the registers ignore the bus but
   // every write is still answered.
   always_comb begin
      wr_ctrl = 1'b0;
      wr_trim = 1'b0;
      wr_unlock = 1'b0;
      wr_select = 1'b0;
      wr_ok = reg_hit(awaddr_q, `SCP_IDX_DIVIDE_CONTROL)
              || reg_hit(awaddr_q, `SCP_IDX_OSC_TRIM)
              || awaddr_q == `SCP_ADDR_STATUS;
      if (do_write && wlane_q && core_rst_n) begin
         wr_ctrl = reg_hit(awaddr_q, `SCP_IDX_DIVIDE_CONTROL);
         wr_trim = reg_hit(awaddr_q, `SCP_IDX_OSC_TRIM);
      end
      if (wr_ctrl) begin
         // Only the exact unlock pattern opens the window.
         wr_unlock = (wbyte_q == `SCP_UNLOCK_VALUE);
         wr_select = (unlock_q == SCP_OPEN)
                     && !wbyte_q[`SCP_BIT_CHANGE_EN];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         w_held_q <= 1'b0;
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wbyte_q <= s_axi_wdata[7:0];
         wlane_q <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SCP_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read path: one read at a time, answered in the next cycle.
   assign s_axi_arready = !s_axi_rvalid;

   // Read word for the address offered this cycle; an unmapped address
   // answers with an error and an all-zero word.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_resp = `SCP_RESP_OKAY;
      if (reg_hit(s_axi_araddr, `SCP_IDX_DIVIDE_CONTROL)) begin
         rd_word = ctrl_view(unlock_q == SCP_OPEN, divide_select_q);
      end else if (reg_hit(s_axi_araddr, `SCP_IDX_OSC_TRIM)) begin
         rd_word = {24'h00_0000, trim_q};
      end else if (s_axi_araddr == `SCP_ADDR_STATUS) begin
         rd_word = status_view(pending_q, active_sel_q);
      end else begin
         rd_resp = `SCP_RESP_SLVERR;
      end
   end

   // Read data and response are registered and stand until taken.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SCP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_resp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// >>> verif/scp_prescaler_properties.sv
`timescale 1ns/1ns
`default_nettype none
module scp_prescaler_properties (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic core_rst_n,
   input wire logic clock_output_fuse,
   input wire logic [7:0] factory_trim,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic io_clock_domain,
   input wire logic cpu_clock_domain,
   input wire logic flash_clock_en,
   input wire logic clock_out_pin_oe,
   input wire logic trim_range_select,
   input wire logic [6:0] trim_tune
);
   logic [8:0] gap_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Cycles since the last system clock tick.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) gap_q <= 9'h000;
      else if (io_clock_domain) gap_q <= 9'h000;
      else gap_q <= gap_q + 9'h001;
   end
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_domains_aligned: assert property (
      io_clock_domain == cpu_clock_domain &&
      io_clock_domain == flash_clock_en) else $error("domain ticks differ");
   a_oe_follows_fuse: assert property (
      $past(arst_n) |-> clock_out_pin_oe == $past(clock_output_fuse))
      else $error("pin enable not fuse");
   a_tick_gap_max: assert property (gap_q < 9'h100)
      else $error("tick gap over 256");
   a_write_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_trim_load: assert property (!core_rst_n |=>
      {trim_range_select, trim_tune} == $past(factory_trim))
      else $error("trim not loaded");
endmodule
bind scp_prescaler scp_prescaler_properties scp_prescaler_properties_inst (
   .clk(clk),
   .arst_n(arst_n),
   .core_rst_n(core_rst_n),
   .clock_output_fuse(clock_output_fuse),
   .factory_trim(factory_trim),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .io_clock_domain(io_clock_domain),
   .cpu_clock_domain(cpu_clock_domain),
   .flash_clock_en(flash_clock_en),
   .clock_out_pin_oe(clock_out_pin_oe),
   .trim_range_select(trim_range_select),
   .trim_tune(trim_tune)
);
`default_nettype wire

// >>> verif/test_system_clock_prescaler.sv
`include "scp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module test_system_clock_prescaler
   import scp_pkg::*;
;
   localparam logic [11:0] A_CTL = `SCP_IDX_DIVIDE_CONTROL << 2;
   localparam logic [11:0] A_TR = `SCP_IDX_OSC_TRIM << 2;
   logic clk = 1'b0, arst_n = 1'b0, core_rst_n = 1'b0;
   logic clock_output_fuse = 1'b1, reset_divide_by_eight_fuse = 1'b0;
   logic [7:0] factory_trim = 8'h00;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic io_clock_domain, cpu_clock_domain, flash_clock_en, clock_out_pin;
   logic clock_out_pin_oe, trim_range_select;
   logic [6:0] trim_tune;
   int err_count = 0, num_checks = 0, seed = 14, sel_m, trim_m, c, t;
   always #5 clk = ~clk;
   scp_prescaler scp_prescaler_inst (
      .clk(clk),
      .arst_n(arst_n),
      .core_rst_n(core_rst_n),
      .clock_output_fuse(clock_output_fuse),
      .reset_divide_by_eight_fuse(reset_divide_by_eight_fuse),
      .factory_trim(factory_trim),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .io_clock_domain(io_clock_domain),
      .cpu_clock_domain(cpu_clock_domain),
      .flash_clock_en(flash_clock_en),
      .clock_out_pin(clock_out_pin),
      .clock_out_pin_oe(clock_out_pin_oe),
      .trim_range_select(trim_range_select),
      .trim_tune(trim_tune)
   );
   task finish_test;
      if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task tmo;
      err_count++;
      $display("unexpected wait exp done got timeout");
      finish_test;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 40) tmo;
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   task rdr(input logic [11:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 40) tmo;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
   // Cycles between two consecutive system clock ticks.
   task per(output int p);
      int n;
      n = 0;
      do begin @(posedge clk); n++; end while (!io_clock_domain && n < 600);
      p = 0;
      do begin @(posedge clk); p++; end while (!io_clock_domain && p < 600);
      if (n == 600 || p == 600) tmo;
   endtask
   task csel;
      int p, e, h;
      e = 1 << (sel_m > 8 ? 8 : sel_m);
      repeat (3) per(p);
      chk("period", e, p);
      h = 0;
      repeat (e) begin
         @(posedge clk);
         h += (clock_out_pin === 1'b1) ? 1 : 0;
      end
      chk("pin high cycles", (e == 1) ? 1 : e / 2, h);
      rdr(`SCP_ADDR_STATUS);
      chk("active code", sel_m, rd[11:8]);
      chk("nominal khz", 32'h1f40, rd[31:16]);
      rdr(A_CTL);
      chk("control", sel_m, rd);
   endtask
   initial begin
      factory_trim <= 8'($random(seed));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      core_rst_n <= 1'b1;
      sel_m = 0;
      trim_m = factory_trim;
      csel;
      rdr(A_TR);
      chk("trim", trim_m, rd);
      for (c = 0; c < 10; c++) begin
         wr(A_CTL, 32'h80);
         wr(A_CTL, c);
         sel_m = c;
         csel;
      end
      wr(A_CTL, 32'h80);
      wr(A_CTL, 32'h2);
      sel_m = 2;
      wr(A_CTL, 32'h5);
      wr(A_CTL, 32'h81);
      wr(A_CTL, 32'h6);
      csel;
      wr(A_CTL, 32'h80);
      rdr(A_CTL);
      chk("control open", sel_m | 32'h80, rd);
      wr(A_CTL, 32'h80);
      wr(A_CTL, 32'h1);
      sel_m = 1;
      csel;
      wr(A_CTL, 32'h80);
      repeat (40) @(posedge clk);
      rdr(A_CTL);
      chk("control closed", sel_m, rd);
      wr(A_CTL, 32'h3);
      csel;
      rdr(12'h010);
      chk("unmapped rresp", `SCP_RESP_SLVERR, rs);
      chk("unmapped rdata", 32'h0, rd);
      wr(12'h010, 32'h1);
      chk("unmapped bresp", `SCP_RESP_SLVERR, rs);
      repeat (3) begin
         rd = $random(seed);
         trim_m = rd[7:0];
         wr(A_TR, rd);
         rdr(A_TR);
         chk("trim", trim_m, rd);
         chk("trim pins", trim_m, {trim_range_select, trim_tune});
      end
      clock_output_fuse <= 1'b0;
      repeat (4) @(posedge clk);
      chk("pin off", 2'b00, {clock_out_pin, clock_out_pin_oe});
      clock_output_fuse <= 1'b1;
      reset_divide_by_eight_fuse <= 1'b1;
      core_rst_n <= 1'b0;
      factory_trim <= 8'($random(seed));
      t = 0;
      repeat (64) begin
         @(posedge clk);
         t += (clock_out_pin !== clock_out_pin_oe) ? 1 : 0;
      end
      chk("pin runs in reset", 1, t > 0);
      core_rst_n <= 1'b1;
      sel_m = 3;
      trim_m = factory_trim;
      csel;
      rdr(A_TR);
      chk("trim", trim_m, rd);
      finish_test;
   end
endmodule
`default_nettype wire
